// [rtl/wdrst_pkg.sv]
// Constants for the watchdog and reset-source block.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
package wdrst_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Register indices and their byte addresses (index times four)
  localparam logic [7:0] IDX_RSRC = 8'hef;
  localparam logic [7:0] IDX_WDT  = 8'hff;
  localparam logic [9:0] ADDR_RSRC = {IDX_RSRC, 2'b00};
  localparam logic [9:0] ADDR_WDT  = {IDX_WDT, 2'b00};
  // Watchdog control keys
  localparam logic [7:0] KEY_START  = 8'ha5;
  localparam logic [7:0] KEY_DIS1   = 8'hde;
  localparam logic [7:0] KEY_DIS2   = 8'had;
  localparam logic [7:0] KEY_LOCK   = 8'hff;
  localparam int WDT_IVL_MSB   = 2;
  localparam int WDT_RUN_BIT   = 4;
  localparam int WDT_SET_BIT   = 7;
  localparam logic [2:0] WDT_IVL_RST = 3'h7;
  localparam int WDT_CNT_W     = 21;
  localparam logic [2:0] DIS_WIN_CYC = 3'h4;
  // Reset source register bit positions
  localparam int RS_PIN = 0;
  localparam int RS_MCD = 2;
  localparam int RS_WDT = 3;
  localparam int RS_CMP = 5;
  localparam int RS_CNV = 6;
  localparam logic [7:0] RSRC_RST = 8'h00;
  // Reset stretch and missing-clock timing
  localparam logic [3:0] STRETCH_CYC = 4'hc;
  localparam int MCD_TIME_NS = 100000;
  localparam int MCD_CYC     = MCD_TIME_NS / CLK_PERIOD_NS;
  // Synchroniser reset levels: run, cnv, cmp, pin
  localparam logic [3:0] SYNC_RST = 4'hf;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_HOLD    = 2'b01,
    ST_STRETCH = 2'b10
  } wdrst_state_type;
endpackage

// [rtl/wdrst_sync.sv]
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes a synchronous active-high reset on the receiving clock.
`timescale 1ns/100ps
module wdrst_sync #(
  parameter int          WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

// [rtl/wdrst_top.sv]
// Watchdog timer and reset-source controller with Wishbone registers.
// Assumes rst_i is the power-on reset and sys_rst_o resets the rest of the chip.
//
// Overview of operation
// RULE_01 - Reset lasts twelve cycles after the reset pin rises; pin flag set on exit.
// RULE_02 - Enabled missing-clock one-shot resets when system clock stops over 100 us.
// RULE_03 - Missing-clock flag reads one only after such reset; pin stays undriven.
// RULE_04 - Writing one to missing-clock bit enables detector; same bit reads the flag.
// RULE_05 - Writing one to comparator enable bit makes comparator a reset source.
// RULE_06 - Enabled comparator resets the device while its output is low.
// RULE_07 - Comparator flag reads one only after comparator reset; pin stays undriven.
// RULE_08 - Software turns on the comparator before enabling it as reset source.
// RULE_09 - Writing one to conversion-start enable bit makes that input a reset source.
// RULE_10 - As reset source that input is active-low level, and starts no conversions.
// RULE_11 - Conversion-start flag reads one only after its reset; pin stays undriven.
// RULE_12 - Software routes the conversion-start pin before enabling it as reset.
// RULE_13 - Watchdog overflow resets device without the pin; software restarts it first.
// RULE_14 - After any reset watchdog runs enabled with the longest interval.
// RULE_15 - Key 0xFF locks out disabling until the next system reset.
// RULE_16 - Watchdog counter is 21 bits on the system clock, reset on overflow.
// RULE_17 - Key 0xA5 enables the watchdog and reloads its counter.
// RULE_18 - Watchdog disabled only by 0xDE then 0xAD within four clocks.
// RULE_19 - Interval bits [2:0] written with bit 7 clear, read back, reset to 111b.
// RULE_20 - Bit 4 of watchdog control reads one while the watchdog runs.
// RULE_21 - Timeout grows with interval; all ones gives the full 21-bit span.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
module wdrst_top
  import wdrst_pkg::*;
#(
  parameter int MCD_CYCLES = wdrst_pkg::MCD_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        rst_pin_n_i,
  input  wire logic        sysclk_run_i,
  input  wire logic        comparator_out_i,
  input  wire logic        convert_start_input_n_i,
  output logic             convert_start_n_o,
  output logic             sys_rst_o
);
  import wdrst_pkg::*;

  localparam int MCD_W = $clog2(MCD_CYCLES + 1);
  localparam logic [MCD_W-1:0] MCD_LAST = MCD_W'(MCD_CYCLES - 1);

  // Synchronised pins
  logic [3:0] pins_s;
  logic       pin_n_s;
  logic       cmp_s;
  logic       cnv_n_s;
  logic       run_s;

  wdrst_sync #(
    .WIDTH   (4),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({sysclk_run_i, convert_start_input_n_i, comparator_out_i, rst_pin_n_i}),
    .sync_o  (pins_s)
  );

  assign pin_n_s = pins_s[0];
  assign cmp_s   = pins_s[1];
  assign cnv_n_s = pins_s[2];
  assign run_s   = pins_s[3];

  // State
  wdrst_state_type       state_reg;
  wdrst_state_type       state_next;
  logic [4:0]            cause_reg;
  logic [4:0]            cause_next;
  logic [4:0]            flags_reg;
  logic [3:0]            stretch_reg;
  logic                  mcd_en_reg;
  logic                  cmp_en_reg;
  logic                  cnv_en_reg;
  logic [MCD_W-1:0]      mcd_cnt_reg;
  logic                  wdt_en_reg;
  logic                  wdt_lock_reg;
  logic [2:0]            wdt_ivl_reg;
  logic [WDT_CNT_W-1:0]  wdt_cnt_reg;
  logic [2:0]            dis_win_reg;
  logic                  ack_reg;
  logic [31:0]           dat_reg;

  // Bus decode
  logic       req;
  logic       wr_fire;
  logic       hit_wdt;
  logic       hit_rsrc;
  logic [7:0] wdata;
  logic       wr_wdt;
  logic       wr_rsrc;
  logic [7:0] rd_wdt;
  logic [7:0] rd_rsrc;
  logic [7:0] rdata;

  assign req      = cyc_i & stb_i;
  assign wr_fire  = req & we_i & ack_reg & sel_i[0];
  assign hit_wdt  = adr_i == ADDR_WDT;
  assign hit_rsrc = adr_i == ADDR_RSRC;
  assign wdata    = dat_i[7:0];
  assign wr_wdt   = wr_fire & hit_wdt;
  assign wr_rsrc  = wr_fire & hit_rsrc;

  // Enables and watchdog state are re-initialised by power-on and by every reset it issues
  logic in_reset;
  logic init;
  assign in_reset = state_reg != ST_RUN;
  assign init     = rst_i | in_reset;

  // Reset triggers
  logic pin_trip;
  logic mcd_trip;
  logic cmp_trip;
  logic cnv_trip;
  logic wdt_trip;
  logic any_trip;
  logic cause_active;
  logic [WDT_CNT_W-1:0] wdt_limit;
  logic [4:0]           wdt_shift;

  assign pin_trip = ~pin_n_s;
  assign mcd_trip = mcd_en_reg & ~run_s & (mcd_cnt_reg == MCD_LAST); // RULE_02
  assign cmp_trip = cmp_en_reg & ~cmp_s;                              // RULE_06
  assign cnv_trip = cnv_en_reg & ~cnv_n_s;                            // RULE_10
  // Limit is 2^(2*ivl+7)-1, so 111b reaches all ones of the counter
  assign wdt_shift = 5'h0e - {1'b0, wdt_ivl_reg, 1'b0};
  assign wdt_limit = {WDT_CNT_W{1'b1}} >> wdt_shift; // RULE_21
  assign wdt_trip = wdt_en_reg & (wdt_cnt_reg >= wdt_limit);           // RULE_13 RULE_16
  assign any_trip = pin_trip | mcd_trip | cmp_trip | cnv_trip | wdt_trip;

  // One-hot cause with pin first: bit order pin, mcd, wdt, cmp, cnv
  always_comb begin
    cause_next = 5'h00;
    if (pin_trip) begin
      cause_next[0] = 1'b1;
    end else if (mcd_trip) begin
      cause_next[1] = 1'b1;
    end else if (cmp_trip) begin
      cause_next[3] = 1'b1;
    end else if (cnv_trip) begin
      cause_next[4] = 1'b1;
    end else if (wdt_trip) begin
      cause_next[2] = 1'b1;
    end
  end

  // Level sources hold the reset for as long as they stay asserted
  assign cause_active = (cause_reg[0] & ~pin_n_s) | (cause_reg[3] & ~cmp_s)
                      | (cause_reg[4] & ~cnv_n_s);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (any_trip) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!cause_active) begin
          state_next = ST_STRETCH; // RULE_01
        end
      end
      ST_STRETCH: begin
        if (cause_active) begin
          state_next = ST_HOLD;
        end else if (stretch_reg == STRETCH_CYC - 4'h1) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_RUN;
      cause_reg   <= 5'h00;
      stretch_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_RUN && any_trip) begin
        cause_reg <= cause_next;
      end
      if (state_reg == ST_STRETCH && !cause_active) begin
        stretch_reg <= stretch_reg + 4'h1; // RULE_01
      end else begin
        stretch_reg <= 4'h0;
      end
    end
  end

  // Source flags, written on exit from each reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= 5'h00;
    end else if (state_reg == ST_STRETCH && state_next == ST_RUN) begin
      flags_reg <= cause_reg; // RULE_01 RULE_03 RULE_07 RULE_11
    end
  end

  // Reset-source enables share bit positions with the flags
  always_ff @(posedge clk_i) begin
    if (init) begin
      mcd_en_reg <= 1'b0;
      cmp_en_reg <= 1'b0;
      cnv_en_reg <= 1'b0;
    end else if (wr_rsrc) begin
      mcd_en_reg <= wdata[RS_MCD]; // RULE_04
      cmp_en_reg <= wdata[RS_CMP]; // RULE_05
      cnv_en_reg <= wdata[RS_CNV]; // RULE_09
    end
  end

  // Missing-clock one-shot, retriggered by every running system clock
  always_ff @(posedge clk_i) begin
    if (init || !mcd_en_reg || run_s) begin
      mcd_cnt_reg <= '0; // RULE_02
    end else if (mcd_cnt_reg != MCD_LAST) begin
      mcd_cnt_reg <= mcd_cnt_reg + MCD_W'(1);
    end
  end

  // Conversion start is withheld from the converter while it is a reset source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      convert_start_n_o <= 1'b1;
    end else begin
      convert_start_n_o <= cnv_en_reg | cnv_n_s; // RULE_10
    end
  end

  // Watchdog control keys
  logic key_start;
  logic key_dis1;
  logic key_dis2;
  logic key_lock;
  logic key_ivl;
  assign key_start = wr_wdt & (wdata == KEY_START);
  assign key_dis1  = wr_wdt & (wdata == KEY_DIS1);
  assign key_dis2  = wr_wdt & (wdata == KEY_DIS2);
  assign key_lock  = wr_wdt & (wdata == KEY_LOCK);
  assign key_ivl   = wr_wdt & ~wdata[WDT_SET_BIT];

  always_ff @(posedge clk_i) begin
    if (init) begin
      wdt_en_reg   <= 1'b1;        // RULE_14
      wdt_lock_reg <= 1'b0;
      wdt_ivl_reg  <= WDT_IVL_RST; // RULE_14 RULE_19
      dis_win_reg  <= 3'h0;
    end else begin
      if (key_lock) begin
        wdt_lock_reg <= 1'b1; // RULE_15
      end
      if (key_dis1) begin
        dis_win_reg <= DIS_WIN_CYC; // RULE_18
      end else if (dis_win_reg != 3'h0) begin
        dis_win_reg <= dis_win_reg - 3'h1;
      end
      if (key_start) begin
        wdt_en_reg <= 1'b1; // RULE_17
      end else if (key_dis2 && dis_win_reg != 3'h0 && !wdt_lock_reg) begin
        wdt_en_reg <= 1'b0; // RULE_18 RULE_15
      end
      if (key_ivl) begin
        wdt_ivl_reg <= wdata[WDT_IVL_MSB:0]; // RULE_19
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (init || !wdt_en_reg || key_start) begin
      wdt_cnt_reg <= '0; // RULE_17
    end else begin
      wdt_cnt_reg <= wdt_cnt_reg + WDT_CNT_W'(1); // RULE_16
    end
  end

  // Read data
  always_comb begin
    rd_wdt = 8'h00;
    rd_wdt[WDT_IVL_MSB:0] = wdt_ivl_reg; // RULE_19
    rd_wdt[WDT_RUN_BIT]   = wdt_en_reg;  // RULE_20
  end

  always_comb begin
    rd_rsrc = RSRC_RST;
    rd_rsrc[RS_PIN] = flags_reg[0];
    rd_rsrc[RS_MCD] = flags_reg[1]; // RULE_03 RULE_04
    rd_rsrc[RS_WDT] = flags_reg[2];
    rd_rsrc[RS_CMP] = flags_reg[3]; // RULE_07
    rd_rsrc[RS_CNV] = flags_reg[4]; // RULE_11
  end

  assign rdata = hit_wdt ? rd_wdt : (hit_rsrc ? rd_rsrc : 8'h00);

  // Wishbone slave: acknowledge one cycle after the request, every address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg && !we_i) begin
        dat_reg <= {24'h00_0000, rdata};
      end
    end
  end

  assign ack_o     = ack_reg;
  assign dat_o     = dat_reg;
  assign sys_rst_o = in_reset; // RULE_13
endmodule

// [bench/wdrst_sva.sv]
// Assertions on the watchdog and reset-source block ports.
// Bound into every wdrst_top; needs the package compiled first.
`timescale 1ns/100ps
module wdrst_sva
  import wdrst_pkg::*;
#(
  parameter int MCD_CYCLES = 20
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        rst_pin_n_i,
  input wire logic        sysclk_run_i,
  input wire logic        comparator_out_i,
  input wire logic        convert_start_input_n_i,
  input wire logic        convert_start_n_o,
  input wire logic        sys_rst_o
);
  logic [7:0] hi_cnt_reg;
  logic       armed_reg;
  wire        rd_ack = ack_o && !we_i;
  wire        wdt_wr = ack_o && we_i && sel_i[0] && adr_i == ADDR_WDT;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Length of the current reset, and re-arm marker until software writes the watchdog control
  always_ff @(posedge clk_i) begin
    hi_cnt_reg <= (rst_i || !sys_rst_o) ? 8'h00 : hi_cnt_reg + {7'h00, hi_cnt_reg != 8'hff};
    armed_reg  <= rst_i || sys_rst_o || (armed_reg && !wdt_wr);
  end
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_pin_hold: assert property ((!rst_pin_n_i)[*5] |-> sys_rst_o)
    else $error("reset pin low without reset");
  chk_pin_release: assert property ((!rst_pin_n_i)[*5] ##1 rst_pin_n_i |-> sys_rst_o[*8])
    else $error("reset ended early after pin release");
  chk_stretch_len: assert property ($fell(sys_rst_o) |-> hi_cnt_reg >= 8'h0c)
    else $error("reset shorter than twelve cycles");
  chk_wdt_rearm: assert property (rd_ack && armed_reg && adr_i == ADDR_WDT |-> dat_o == 32'h0000_0017)
    else $error("watchdog not re-armed after reset");
  chk_ctrl_fields: assert property (rd_ack && adr_i == ADDR_WDT |-> dat_o[31:5] == 27'h000_0000 && !dat_o[3])
    else $error("control read has stray bits");
  chk_flag_single: assert property (rd_ack && adr_i == ADDR_RSRC |-> $onehot0(dat_o) && !dat_o[7])
    else $error("more than one reset cause flagged");
endmodule

bind wdrst_top wdrst_sva #(.MCD_CYCLES(MCD_CYCLES)) u_wdrst_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .rst_pin_n_i, .sysclk_run_i, .comparator_out_i, .convert_start_input_n_i,
  .convert_start_n_o, .sys_rst_o);

// [bench/wdrst_top_bench.sv]
// Self-checking bench for the watchdog and reset-source block.
// Drives Wishbone and all reset inputs itself; the checker is bound in.
`timescale 1ns/100ps
module wdrst_top_bench;
  import wdrst_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [9:0]  adr_i = 10'h000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        convert_start_n_o;
  logic        sys_rst_o;
  logic        rst_pin_n_i = 1'b1;
  logic        sysclk_run_i = 1'b1;
  logic        comparator_out_i = 1'b1;
  logic        convert_start_input_n_i = 1'b1;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cycles = 0;
  int          seed = 17575;
  int          n;
  int          exp_ivl = 7;
  int          exp_en = 1;
  logic [7:0]  q;
  logic [7:0]  bits [3] = '{8'h20, 8'h40, 8'h04};
  always #5 clk_i = ~clk_i;
  wdrst_top #(.MCD_CYCLES(20)) u_wdrst_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .rst_pin_n_i, .sysclk_run_i, .comparator_out_i, .convert_start_input_n_i,
    .convert_start_n_o, .sys_rst_o);
  task automatic stop_test;
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // One classic cycle; holds the request until ack is sampled high
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    chk("ack", 8'h02, 8'(k));
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask
  function automatic logic [7:0] ctrl_exp();
    return {3'h0, exp_en[0], 1'b0, exp_ivl[2:0]};
  endfunction
  task automatic wait_lvl(input logic lvl, input int lim);
    n = 0;
    while (sys_rst_o !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("reset level", {7'h00, lvl}, sys_rst_o);
  endtask
  task automatic drive(input int i, input logic act);
    case (i)
      0: comparator_out_i <= !act;
      1: convert_start_input_n_i <= !act;
      default: sysclk_run_i <= !act;
    endcase
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_WDT, ctrl_exp(), "ctrl");
    rd(ADDR_RSRC, 8'h00, "source");
    bus(1'b1, 10'h000, 8'h00);
    rd(10'h000, 8'h00, "unmapped");
    rd(ADDR_WDT, ctrl_exp(), "ctrl");
    bus(1'b1, ADDR_WDT, KEY_START);
    repeat (4) begin
      exp_ivl = $random(seed) & 7;
      bus(1'b1, ADDR_WDT, 8'(exp_ivl));
      rd(ADDR_WDT, ctrl_exp(), "interval");
    end
    exp_ivl = 7;
    bus(1'b1, ADDR_WDT, 8'h07);
    bus(1'b1, ADDR_WDT, KEY_DIS1);
    repeat (2) @(posedge clk_i);
    bus(1'b1, ADDR_WDT, KEY_DIS2);
    rd(ADDR_WDT, ctrl_exp(), "late disable");
    bus(1'b1, ADDR_WDT, KEY_DIS1);
    bus(1'b1, ADDR_WDT, KEY_DIS2);
    exp_en = 0;
    rd(ADDR_WDT, ctrl_exp(), "disable");
    bus(1'b1, ADDR_WDT, KEY_START);
    exp_en = 1;
    rd(ADDR_WDT, ctrl_exp(), "enable");
    bus(1'b1, ADDR_WDT, 8'h00);
    repeat (3) begin
      repeat (60) @(posedge clk_i);
      bus(1'b1, ADDR_WDT, KEY_START);
    end
    repeat (100) @(posedge clk_i);
    chk("early trip", 8'h00, sys_rst_o);
    wait_lvl(1'b1, 60);
    wait_lvl(1'b0, 40);
    rd(ADDR_RSRC, 8'h08, "wdt flag");
    rd(ADDR_WDT, ctrl_exp(), "rearm");
    bus(1'b1, ADDR_WDT, KEY_LOCK);
    bus(1'b1, ADDR_WDT, KEY_DIS1);
    bus(1'b1, ADDR_WDT, KEY_DIS2);
    rd(ADDR_WDT, ctrl_exp(), "locked");
    // Comparator, conversion start, missing clock in turn
    for (int i = 0; i < 3; i++) begin
      drive(i, 1'b1);
      repeat (30) @(posedge clk_i);
      chk("no enable", 8'h00, sys_rst_o);
      if (i == 1) chk("cnv pass", 8'h00, convert_start_n_o);
      drive(i, 1'b0);
      repeat (4) @(posedge clk_i);
      bus(1'b1, ADDR_RSRC, bits[i]);
      drive(i, 1'b1);
      wait_lvl(1'b1, 40);
      drive(i, 1'b0);
      wait_lvl(1'b0, 40);
      rd(ADDR_RSRC, bits[i], "flag");
    end
    rst_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_pin_n_i <= 1'b1;
    wait_lvl(1'b0, 40);
    chk("stretch", 8'h01, n >= 12);
    rd(ADDR_RSRC, 8'h01, "pin flag");
    stop_test();
  end
endmodule
